// ===== dis_defines.vh
// Constants for the two-wire converter command port
`ifndef DIS_DEFINES_VH
`define DIS_DEFINES_VH
`define DIS_DEV_CODE        4'ha
`define DIS_FACTORY_ADDR    2'h0
`define DIS_GCALL_ADDR      8'h00
`define DIS_GCALL_RESET     8'h06
`define DIS_GCALL_WAKE      8'h09
`define DIS_HS_CODE_TOP     5'h01
`define DIS_NVM_DEF_PD      2'h0
`define DIS_NVM_DEF_CODE    12'h800
`define DIS_NVM_WRITE_NS    25000000
`define DIS_CLK_NS          50
`define DIS_READ_BYTES      3'h5
`endif

// ===== dis_sync.v
// Two-flip-flop synchroniser for one level
module dis_sync (
  input  wire CLK_SYS,
  input  wire RST,
  input  wire d,
  output reg  q
);
  reg meta;
  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      meta <= 1'b1;
      q    <= 1'b1;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

// ===== dis_nvm_timer.v
// Busy timer standing in for the nonvolatile write time
module dis_nvm_timer #(
  parameter CYCLES = 500000
) (
  input  wire CLK_SYS,
  input  wire RST,
  input  wire start,
  output wire busy,
  output reg  done
);
  reg [31:0] count;
  assign busy = (count != 32'h0);
  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      count <= 32'h0;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        count <= CYCLES;
      end else if (busy) begin
        count <= count - 32'h1;
        if (count == 32'h1) begin
          done <= 1'b1;
        end
      end
    end
  end
endmodule

// ===== dis_slave.v
// Two-wire slave command port of a 12-bit converter with stored setting
// Overview of operation
// - Reserved command types change nothing
// - Fast write ignores lowest command bit
// - Read returns converter then stored contents
// - Status byte ready flag low while storing
// - Master ends read by nack or restart
// - Byte after write address carries command
// - Match device code, address bits, direction
// - Upper address bits are factory constants
// - Lowest address bit compared with pin
// - Acknowledge general call, decode next byte
// - General reset reloads stored contents
// - Wake-up clears register power-down bits
// - Master code unacknowledged, enters high speed
// - Stop returns to normal speed
// - Standard, fast and high-speed rates supported
// - Start and stop seen while clock high
// - Data changes only while clock low
// - Hold data low through acknowledge clock
// - Release data after master's final nack
// - Three-bit command type decode
// - Apply write after fourth byte, fast write after third
// - Ignore writes while storing is busy
// - Fast write sets power-down and code
`include "dis_defines.vh"
module dis_slave #(
  parameter NVM_WRITE_CYCLES = `DIS_NVM_WRITE_NS / `DIS_CLK_NS,
  parameter [1:0] FACTORY_ADDR = `DIS_FACTORY_ADDR
) (
  input  wire        CLK_SYS,
  input  wire        RST,
  input  wire        SCL_IN,
  input  wire        SDA_IN,
  output wire        SDA_OUT,
  output reg         SDA_OE_N,
  input  wire        ADDR_SELECT_PIN,
  output reg  [11:0] DAC_CODE,
  output reg  [1:0]  POWERDOWN_SEL,
  output reg  [11:0] NVM_CODE,
  output reg  [1:0]  NVM_POWERDOWN,
  output wire        NVM_WRITE_BUSY,
  output reg         HIGH_SPEED_MODE,
  output reg         GCALL_RESET_PULSE
);
  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  wire scl_s;
  wire sda_s;
  wire a0_s;
  dis_sync u_scl (.CLK_SYS(CLK_SYS), .RST(RST), .d(SCL_IN),          .q(scl_s));
  dis_sync u_sda (.CLK_SYS(CLK_SYS), .RST(RST), .d(SDA_IN),          .q(sda_s));
  // Address pin is only sampled, never latched: it must settle before traffic
  dis_sync u_a0  (.CLK_SYS(CLK_SYS), .RST(RST), .d(ADDR_SELECT_PIN), .q(a0_s));

  reg scl_d;
  reg sda_d;
  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end
  // Each bus level must last two system clocks, which bounds the usable bit rate
  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire start_ev = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_ev  = scl_s & scl_d & ~sda_d & sda_s;

  ////////////////////////////////////////////////////////////////////////
  // Nonvolatile write timer
  // Only the busy time is modelled; the stored setting is the registers below
  reg  nvm_start;
  dis_nvm_timer #(.CYCLES(NVM_WRITE_CYCLES)) u_nvm (
    .CLK_SYS(CLK_SYS),
    .RST    (RST),
    .start  (nvm_start),
    .busy   (NVM_WRITE_BUSY),
    .done   ()
  );
  wire nvm_write_done_flag = ~NVM_WRITE_BUSY;

  ////////////////////////////////////////////////////////////////////////
  // Byte engine
  localparam ST_IDLE  = 3'h0;
  localparam ST_RX    = 3'h1;
  localparam ST_RXACK = 3'h2;
  localparam ST_TX    = 3'h3;
  localparam ST_TXACK = 3'h4;
  localparam ST_IGN   = 3'h5;

  // Meaning of the next received byte
  localparam K_ADDR  = 2'h0;
  localparam K_WRITE = 2'h1;
  localparam K_GCALL = 2'h2;

  reg [2:0]  state;
  reg [1:0]  kind;
  reg [2:0]  bit_cnt;
  reg [7:0]  shreg;
  reg [2:0]  byte_idx;
  reg        ack_now;
  reg        drive_low;
  reg [7:0]  cmd_byte;
  reg [7:0]  mid_byte;
  reg [2:0]  rd_idx;
  reg [7:0]  tx_byte;
  reg        gc_rst_pend;
  wire [7:0] rx_byte = {shreg[6:0], sda_s};

  assign SDA_OUT = 1'b0;

  // Read image: status, live code, then stored pair; wraps after five bytes
  function [7:0] read_byte;
    input [2:0]  idx;
    input        rdy;
    input [1:0]  pd;
    input [11:0] code;
    input [1:0]  npd;
    input [11:0] ncode;
    begin
      case (idx)
        3'h0:    read_byte = {rdy, 4'h0, pd, 1'b0};
        3'h1:    read_byte = code[11:4];
        3'h2:    read_byte = {code[3:0], 4'h0};
        3'h3:    read_byte = {1'b0, npd, 1'b0, ncode[11:8]};
        default: read_byte = ncode[7:0];
      endcase
    end
  endfunction

  wire [7:0] rd_now = read_byte(rd_idx, nvm_write_done_flag, POWERDOWN_SEL,
                                DAC_CODE, NVM_POWERDOWN, NVM_CODE);
  wire       addr_match = (rx_byte[7:4] == `DIS_DEV_CODE)
                       && (rx_byte[3:2] == FACTORY_ADDR)
                       && (rx_byte[1] == a0_s);
  // Busy writes are still acknowledged but change nothing
  wire       write_ok = ~NVM_WRITE_BUSY;

  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      state             <= ST_IDLE;
      kind              <= K_ADDR;
      bit_cnt           <= 3'h0;
      shreg             <= 8'h00;
      byte_idx          <= 3'h0;
      ack_now           <= 1'b0;
      drive_low         <= 1'b0;
      cmd_byte          <= 8'h00;
      mid_byte          <= 8'h00;
      rd_idx            <= 3'h0;
      tx_byte           <= 8'h00;
      SDA_OE_N          <= 1'b1;
      DAC_CODE          <= `DIS_NVM_DEF_CODE;
      POWERDOWN_SEL     <= `DIS_NVM_DEF_PD;
      NVM_CODE          <= `DIS_NVM_DEF_CODE;
      NVM_POWERDOWN     <= `DIS_NVM_DEF_PD;
      HIGH_SPEED_MODE   <= 1'b0;
      GCALL_RESET_PULSE <= 1'b0;
      nvm_start         <= 1'b0;
      gc_rst_pend       <= 1'b0;
    end else begin
      nvm_start         <= 1'b0;
      GCALL_RESET_PULSE <= 1'b0;
      if (stop_ev) begin
        HIGH_SPEED_MODE <= 1'b0;
      end
      if (start_ev || stop_ev) begin
        // Partial frames are simply dropped here
        state     <= start_ev ? ST_RX : ST_IDLE;
        kind      <= K_ADDR;
        bit_cnt   <= 3'h0;
        byte_idx  <= 3'h0;
        drive_low <= 1'b0;
        SDA_OE_N  <= 1'b1;
        // A general reset cut short by start or stop is dropped
        gc_rst_pend <= 1'b0;
      end else begin
        // Output changes on the falling edge only, so data moves while clock is low
        if (scl_fall) begin
          SDA_OE_N <= ~drive_low;
        end
        case (state)
          ST_IDLE: begin
            SDA_OE_N <= 1'b1;
          end
          ST_RX: begin
            if (scl_rise) begin
              shreg   <= rx_byte;
              bit_cnt <= bit_cnt + 3'h1;
              if (bit_cnt == 3'h7) begin
                state   <= ST_RXACK;
                ack_now <= 1'b0;
                case (kind)
                  K_ADDR: begin
                    if (rx_byte == `DIS_GCALL_ADDR) begin
                      ack_now <= 1'b1;
                      kind    <= K_GCALL;
                    end else if (rx_byte[7:3] == `DIS_HS_CODE_TOP) begin
                      // Left unacknowledged; the rest of this frame is ignored
                      HIGH_SPEED_MODE <= 1'b1;
                    end else if (addr_match && rx_byte[0]) begin
                      ack_now <= 1'b1;
                      // Reads always open with the status byte
                      rd_idx  <= 3'h0;
                    end else if (addr_match) begin
                      ack_now <= 1'b1;
                      kind    <= K_WRITE;
                    end
                  end
                  K_GCALL: begin
                    ack_now <= 1'b1;
                    if (rx_byte == `DIS_GCALL_WAKE) begin
                      POWERDOWN_SEL <= 2'h0;
                    end else if (rx_byte == `DIS_GCALL_RESET) begin
                      gc_rst_pend <= 1'b1;
                    end
                  end
                  default: begin
                    ack_now <= 1'b1;
                    if (byte_idx == 3'h0) begin
                      cmd_byte <= rx_byte;
                      if (rx_byte[7:6] == 2'h0) begin
                        // Fast write: pd and code high nibble in this byte
                        byte_idx <= 3'h2;
                      end else begin
                        byte_idx <= 3'h1;
                      end
                    end else if (byte_idx == 3'h1) begin
                      mid_byte <= rx_byte;
                      byte_idx <= 3'h3;
                    end else if (byte_idx == 3'h2) begin
                      // Only a fast write lands here, with its low code byte
                      byte_idx <= 3'h0;
                      if (write_ok) begin
                        POWERDOWN_SEL <= cmd_byte[5:4];
                        DAC_CODE      <= {cmd_byte[3:0], rx_byte};
                      end
                    end else begin
                      // A following byte opens a fresh command, a triple or a fast-write pair
                      byte_idx <= 3'h0;
                      if (write_ok && cmd_byte[7:6] == 2'h1) begin
                        POWERDOWN_SEL <= cmd_byte[2:1];
                        DAC_CODE      <= {mid_byte, rx_byte[7:4]};
                        if (cmd_byte[5]) begin
                          NVM_POWERDOWN <= cmd_byte[2:1];
                          NVM_CODE      <= {mid_byte, rx_byte[7:4]};
                          nvm_start     <= 1'b1;
                        end
                      end
                    end
                  end
                endcase
              end
            end
            if (scl_fall && bit_cnt == 3'h0 && byte_idx == 3'h0 && kind == K_ADDR) begin
              drive_low <= 1'b0;
            end
          end
          // Acknowledge spans one whole clock: low after one fall, freed at the next
          ST_RXACK: begin
            if (scl_fall) begin
              if (!ack_now) begin
                state     <= ST_IGN;
                drive_low <= 1'b0;
                SDA_OE_N  <= 1'b1;
              end else if (!drive_low) begin
                drive_low <= 1'b1;
                SDA_OE_N  <= 1'b0;
              end else begin
                drive_low <= 1'b0;
                SDA_OE_N  <= 1'b1;
                bit_cnt   <= 3'h0;
                if (gc_rst_pend) begin
                  // General reset reloads the register from storage
                  gc_rst_pend       <= 1'b0;
                  GCALL_RESET_PULSE <= 1'b1;
                  DAC_CODE          <= NVM_CODE;
                  POWERDOWN_SEL     <= NVM_POWERDOWN;
                  HIGH_SPEED_MODE   <= 1'b0;
                  state             <= ST_IGN;
                end else if (kind == K_ADDR) begin
                  tx_byte   <= rd_now;
                  drive_low <= ~rd_now[7];
                  SDA_OE_N  <= rd_now[7];
                  state     <= ST_TX;
                end else begin
                  state <= ST_RX;
                end
              end
            end
          end
          // Bit seven is already on the line; the rest follow each falling edge
          ST_TX: begin
            if (scl_fall) begin
              bit_cnt   <= bit_cnt + 3'h1;
              tx_byte   <= {tx_byte[6:0], 1'b0};
              if (bit_cnt == 3'h7) begin
                drive_low <= 1'b0;
                SDA_OE_N  <= 1'b1;
                state     <= ST_TXACK;
              end else begin
                drive_low <= ~tx_byte[6];
                SDA_OE_N  <= tx_byte[6];
              end
            end
          end
          ST_TXACK: begin
            if (scl_rise) begin
              if (sda_s) begin
                state <= ST_IGN;
              end else begin
                rd_idx <= (rd_idx == `DIS_READ_BYTES - 3'h1) ? 3'h0 : rd_idx + 3'h1;
              end
            end
            // Acknowledged: the next byte goes out as the acknowledge clock ends
            if (scl_fall) begin
              bit_cnt   <= 3'h0;
              tx_byte   <= rd_now;
              drive_low <= ~rd_now[7];
              SDA_OE_N  <= rd_now[7];
              state     <= ST_TX;
            end
          end
          // Ignored until the next start or stop
          default: begin
            SDA_OE_N  <= 1'b1;
            drive_low <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule

// ===== dis_bus_master.sv
// Behavioural two-wire bus master for the converter command port
module dis_bus_master (
  output reg  scl,
  output reg  sda,
  input  wire sda_bus
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [7:0] rx;
  event     got;
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  ////////////////////////////////////////
  task bit_out(input b);
    #50 sda = b;
    #200 scl = 1'b1;
    #150 scl = 1'b0;
  endtask
  // Released line reads high through the pull-up
  task bit_in(output b);
    sda = 1'b1;
    #250 scl = 1'b1;
    #100 b = sda_bus;
    #50 scl = 1'b0;
  endtask
  task start_c;
    #50 sda = 1'b1;
    #100 scl = 1'b1;
    #200 sda = 1'b0;
    #200 scl = 1'b0;
  endtask
  task stop_c;
    #50 sda = 1'b0;
    #200 scl = 1'b1;
    #200 sda = 1'b1;
    #400;
  endtask
  task wr_byte(input [7:0] d);
    integer i;
    reg     a;
    for (i = 7; i >= 0; i = i - 1) bit_out(d[i]);
    bit_in(a);
    rx = {7'h0, ~a};
    -> got;
  endtask
  task rd_byte(input last);
    integer i;
    for (i = 7; i >= 0; i = i - 1) bit_in(rx[i]);
    bit_out(last);
    -> got;
  endtask
endmodule

// ===== dis_slave_asserts.sv
// Protocol checker for the converter command port
module dis_slave_asserts #(
  parameter NVM_WRITE_CYCLES = 20
) (
  input wire        CLK_SYS,
  input wire        RST,
  input wire        SCL_IN,
  input wire        SDA_IN,
  input wire        SDA_OUT,
  input wire        SDA_OE_N,
  input wire [11:0] DAC_CODE,
  input wire [1:0]  POWERDOWN_SEL,
  input wire [11:0] NVM_CODE,
  input wire [1:0]  NVM_POWERDOWN,
  input wire        NVM_WRITE_BUSY,
  input wire        HIGH_SPEED_MODE,
  input wire        GCALL_RESET_PULSE
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  reg [31:0] busy_cnt;
  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) busy_cnt <= 32'h0;
    else busy_cnt <= NVM_WRITE_BUSY ? busy_cnt + 32'h1 : 32'h0;
  end
  sequence stop_seen;
    SCL_IN && $rose(SDA_IN);
  endsequence
  sequence ack_held;
    !SDA_OE_N [*5];
  endsequence
  ////////////////////////////////////////
  sda_out_zero_a: assert property (SDA_OUT == 1'b0)
    else $error("data output not low");
  oe_clk_low_a: assert property ($changed(SDA_OE_N) |-> !SCL_IN)
    else $error("data drive changed with clock high");
  ack_stands_a: assert property ($fell(SDA_OE_N) |-> ack_held)
    else $error("driven low bit too short");
  hs_stop_clear_a: assert property (HIGH_SPEED_MODE ##0 stop_seen |-> ##[1:6] !HIGH_SPEED_MODE)
    else $error("high speed kept after stop");
  hs_no_ack_a: assert property ($rose(HIGH_SPEED_MODE) |-> SDA_OE_N [*8])
    else $error("master code acknowledged");
  gcall_pulse_a: assert property (GCALL_RESET_PULSE |=> !GCALL_RESET_PULSE)
    else $error("reset pulse longer than one cycle");
  gcall_reload_a: assert property ($rose(GCALL_RESET_PULSE) |->
    ##[0:3] (DAC_CODE == NVM_CODE && POWERDOWN_SEL == NVM_POWERDOWN))
    else $error("stored contents not reloaded");
  busy_hold_a: assert property ($rose(NVM_WRITE_BUSY) |=> NVM_WRITE_BUSY [*8])
    else $error("busy dropped early");
  busy_bound_a: assert property (busy_cnt <= NVM_WRITE_CYCLES + 2)
    else $error("busy too long");
endmodule
bind dis_slave dis_slave_asserts #(.NVM_WRITE_CYCLES(NVM_WRITE_CYCLES)) i_chk (.CLK_SYS(CLK_SYS), .RST(RST),
  .SCL_IN(SCL_IN), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N), .DAC_CODE(DAC_CODE),
  .POWERDOWN_SEL(POWERDOWN_SEL), .NVM_CODE(NVM_CODE), .NVM_POWERDOWN(NVM_POWERDOWN),
  .NVM_WRITE_BUSY(NVM_WRITE_BUSY), .HIGH_SPEED_MODE(HIGH_SPEED_MODE), .GCALL_RESET_PULSE(GCALL_RESET_PULSE));

// ===== tb_dis_slave.sv
// Self-checking bench for the converter command port
`include "dis_defines.vh"
module tb_dis_slave;
  timeunit 1ns;
  timeprecision 1ps;
  localparam NVW = 2000;
  reg         clk_sys;
  reg         rst = 1'b1;
  reg         a0;
  wire        scl;
  wire        sda_m;
  wire        sda_bus;
  wire        sda_out;
  wire        sda_oe_n;
  wire [11:0] dac_code;
  wire [1:0]  pd_sel;
  wire [11:0] nvm_code;
  wire [1:0]  nvm_pd;
  wire        busy;
  wire        hsm;
  wire        gcall;
  integer     seed = 32'h92a7;
  integer     failures = 0;
  integer     checks_done = 0;
  integer     pulses = 0;
  integer     i;
  reg [7:0]   exp_q[$];
  reg [11:0]  code;
  reg [1:0]   pd;
  reg [11:0]  ncode = 12'h800;
  reg [1:0]   npd = 2'h0;
  assign sda_bus = sda_m & (sda_oe_n | sda_out);
  dis_slave #(.NVM_WRITE_CYCLES(NVW)) i_dut (.CLK_SYS(clk_sys), .RST(rst), .SCL_IN(scl), .SDA_IN(sda_bus),
    .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n), .ADDR_SELECT_PIN(a0), .DAC_CODE(dac_code), .POWERDOWN_SEL(pd_sel),
    .NVM_CODE(nvm_code), .NVM_POWERDOWN(nvm_pd), .NVM_WRITE_BUSY(busy), .HIGH_SPEED_MODE(hsm),
    .GCALL_RESET_PULSE(gcall));
  dis_bus_master i_mst (.scl(scl), .sda(sda_m), .sda_bus(sda_bus));
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  always @(negedge clk_sys) if (gcall === 1'b1) pulses = pulses + 1;
  always @(i_mst.got) check(i_mst.rx, exp_q.pop_front());
  ////////////////////////////////////////
  task check(input [15:0] seen, input [15:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task test_done;
    if (failures == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task send(input [7:0] d, input ack);
    exp_q.push_back({7'h0, ack});
    i_mst.wr_byte(d);
  endtask
  task wr(input [23:0] b, input integer n);
    integer k;
    i_mst.start_c();
    send({`DIS_DEV_CODE, `DIS_FACTORY_ADDR, a0, 1'b0}, 1'b1);
    for (k = 0; k < n; k = k + 1) send(b[23-8*k -: 8], 1'b1);
    i_mst.stop_c();
  endtask
  task rd(input rdy, input integer n);
    reg [39:0] img;
    integer    k;
    img = {rdy, 4'h0, pd, 1'b0, code, 4'h0, 1'b0, npd, 1'b0, ncode};
    i_mst.start_c();
    send({`DIS_DEV_CODE, `DIS_FACTORY_ADDR, a0, 1'b1}, 1'b1);
    for (k = 0; k < n; k = k + 1) begin
      exp_q.push_back(img[39-8*k -: 8]);
      i_mst.rd_byte(k == n - 1);
    end
    i_mst.stop_c();
  endtask
  task gc(input [7:0] b);
    i_mst.start_c();
    send(`DIS_GCALL_ADDR, 1'b1);
    send(b, 1'b1);
    i_mst.stop_c();
  endtask
  ////////////////////////////////////////
  initial begin
    a0 = 1'($random(seed));
    repeat (4) @(negedge clk_sys);
    rst = 1'b0;
    repeat (4) @(negedge clk_sys);
    code = 12'h800;
    pd = 2'h0;
    check(dac_code, code);
    check(sda_oe_n, 1'b1);
    i_mst.start_c();
    send({`DIS_DEV_CODE, `DIS_FACTORY_ADDR, ~a0, 1'b0}, 1'b0);
    i_mst.start_c();
    send({`DIS_HS_CODE_TOP, 3'($random(seed))}, 1'b0);
    check(hsm, 1'b1);
    i_mst.stop_c();
    check(hsm, 1'b0);
    code = 12'($random(seed));
    pd = 2'($random(seed));
    wr({2'b00, pd, code, 8'h0}, 2);
    check(dac_code, code);
    check(pd_sel, pd);
    wr({3'b010, 2'h0, ~pd, 1'b0, ~code[11:4], 8'h0}, 2);
    check(dac_code, code);
    code = 12'($random(seed));
    pd = 2'($random(seed));
    wr({3'b010, 2'h0, pd, 1'b0, code, 4'h0}, 3);
    check(dac_code, code);
    check(pd_sel, pd);
    for (i = 4; i < 8; i = i + 1) begin
      wr({i[2:0], 2'h0, ~pd, 1'b0, ~code, 4'h0}, 3);
      check(dac_code, code);
    end
    code = 12'($random(seed));
    pd = 2'h1 | 2'($random(seed));
    ncode = code;
    npd = pd;
    wr({3'b011, 2'h0, pd, 1'b0, code, 4'h0}, 3);
    check(busy, 1'b1);
    rd(1'b0, 1);
    wr({3'b010, 2'h0, ~pd, 1'b0, ~code, 4'h0}, 3);
    check(dac_code, code);
    for (i = 0; i < 4000 && busy; i = i + 1) @(negedge clk_sys);
    check(nvm_code, ncode);
    check(nvm_pd, npd);
    rd(1'b1, 5);
    rd(1'b1, 2);
    check(sda_oe_n, 1'b1);
    gc(8'h04);
    check(pd_sel, pd);
    gc(8'h09);
    pd = 2'h0;
    check(pd_sel, pd);
    check(nvm_pd, npd);
    code = ~ncode;
    wr({2'b00, 2'h3, code, 8'h0}, 2);
    check(dac_code, code);
    check(pd_sel, 2'h3);
    gc(8'h06);
    check(dac_code, ncode);
    check(pd_sel, npd);
    check(pulses[15:0], 16'h1);
    test_done;
  end
  // Generous limit: the sequence needs well under half a millisecond
  initial begin
    #2000000;
    failures = failures + 1;
    test_done;
  end
endmodule
